// >>> rtl/sioexp_top.v
// Serial I/O bus expander: fan-out, interrupt sections A/B, direct interrupt merge
`timescale 1ns/1ps
`include "sioexp_defines.vh"
module sioexp_top (
	// Clock and reset
	input wire core_clk_i,
	input wire arst_n_i,
	// Processor side of the serial I/O bus
	input wire [`SIOEXP_ADDR_W-1:0] serial_addr_i,
	input wire serial_store_clk_i,
	input wire serial_write_bit_i,
	output reg serial_read_bit_o,
	// Board select from slot 1 of this chassis
	input wire board_select_n_i,
	// Fan-out to expansion chassis
	output reg [`SIOEXP_ADDR_W-1:0] chassis_addr_o,
	output reg chassis_store_clk_o,
	output reg chassis_write_bit_o,
	input wire [`SIOEXP_NCH-1:0] chassis_read_bit_i,
	// Interrupt scan from chassis buffer boards
	input wire [`SIOEXP_NCH-1:0] chassis_int_present_i,
	input wire [`SIOEXP_NCH-1:0] chassis_online_i,
	input wire [`SIOEXP_NCH*`SIOEXP_ID_W-1:0] chassis_id_i,
	output reg [`SIOEXP_NCH-1:0] chassis_id_enable_o,
	input wire [`SIOEXP_NCH-1:0] chassis_direct_req_n_i,
	// Section enables (jumpers)
	input wire sec_a_enable_i,
	input wire sec_b_enable_i,
	// Interrupts to processor
	output reg group_a_irq_o,
	output reg group_b_irq_o,
	output reg direct_irq_n_o
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Active-low pins are inverted ahead of the flops, so that the
	// cleared synchroniser reads as idle and no false request follows reset
	localparam CTL_W = 5;
	wire [`SIOEXP_ADDR_W-1:0] addr_s;
	wire [`SIOEXP_NCH-1:0] rbit_s;
	wire [`SIOEXP_NCH-1:0] pend_s;
	wire [`SIOEXP_NCH-1:0] onl_s;
	wire [`SIOEXP_NCH-1:0] dreq_s;
	wire [`SIOEXP_NCH*`SIOEXP_ID_W-1:0] id_s;
	wire stclk_s;
	wire wbit_s;
	wire sel_s;
	wire en_a_s;
	wire en_b_s;
	sioexp_sync #(.W(`SIOEXP_ADDR_W)) u_sync_addr (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(serial_addr_i),
		.q_o(addr_s)
	);
	sioexp_sync #(.W(`SIOEXP_NCH)) u_sync_rbit (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(chassis_read_bit_i),
		.q_o(rbit_s)
	);
	sioexp_sync #(.W(`SIOEXP_NCH)) u_sync_pend (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(chassis_int_present_i),
		.q_o(pend_s)
	);
	sioexp_sync #(.W(`SIOEXP_NCH)) u_sync_onl (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(chassis_online_i),
		.q_o(onl_s)
	);
	sioexp_sync #(.W(`SIOEXP_NCH)) u_sync_dreq (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(~chassis_direct_req_n_i),
		.q_o(dreq_s)
	);
	// Each chassis returns its own id lines on its own cable
	sioexp_sync #(.W(`SIOEXP_NCH*`SIOEXP_ID_W)) u_sync_id (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i(chassis_id_i),
		.q_o(id_s)
	);
	sioexp_sync #(.W(CTL_W)) u_sync_ctl (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.d_i({serial_store_clk_i, serial_write_bit_i, ~board_select_n_i, sec_a_enable_i, sec_b_enable_i}),
		.q_o({stclk_s, wbit_s, sel_s, en_a_s, en_b_s})
	);

	// ----------------------------------------
	// Bus fan-out
	// ----------------------------------------
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chassis_addr_o <= {`SIOEXP_ADDR_W{1'b0}};
			chassis_store_clk_o <= 1'b0;
			chassis_write_bit_o <= 1'b0;
		end else begin
			chassis_addr_o <= addr_s;
			chassis_store_clk_o <= stclk_s;
			chassis_write_bit_o <= wbit_s;
		end
	end

	// ----------------------------------------
	// Store clock edge detect
	// ----------------------------------------
	reg stclk_d;
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			stclk_d <= 1'b0;
		else
			stclk_d <= stclk_s;
	end
	wire stclk_rise = stclk_s & ~stclk_d;

	// ----------------------------------------
	// Interrupt recognition, sections A and B
	// ----------------------------------------
	wire [`SIOEXP_NCH-1:0] act;
	assign act = pend_s & {{`SIOEXP_CH_B_W{en_b_s}}, {`SIOEXP_CH_A_W{en_a_s}}};
	wire [`SIOEXP_CH_A_W-1:0] act_a = act[`SIOEXP_CH_A_W-1:0];
	wire [`SIOEXP_CH_B_W-1:0] act_b = act[`SIOEXP_NCH-1:`SIOEXP_CH_B_LO];
	// Lowest chassis number wins in each section
	wire [`SIOEXP_CH_A_W-1:0] win_a = act_a & (~act_a + 4'h1);
	wire [`SIOEXP_CH_B_W-1:0] win_b = act_b & (~act_b + 3'h1);
	reg [2:0] num_a;
	reg [2:0] num_b;
	reg [`SIOEXP_ID_W-1:0] id_a;
	reg [`SIOEXP_ID_W-1:0] id_b;
	integer i;
	// Both sections may hold an enabled chassis at once; each takes only its own winner's lane
	always @* begin
		num_a = 3'h0;
		num_b = 3'h0;
		id_a = {`SIOEXP_ID_W{1'b0}};
		id_b = {`SIOEXP_ID_W{1'b0}};
		for (i = 0; i < `SIOEXP_CH_A_W; i = i + 1)
			if (win_a[i]) begin
				num_a = i[2:0] + 3'h1;
				id_a = id_s[i*`SIOEXP_ID_W +: `SIOEXP_ID_W];
			end
		for (i = 0; i < `SIOEXP_CH_B_W; i = i + 1)
			if (win_b[i]) begin
				num_b = i[2:0] + `SIOEXP_CH_B_NUM0;
				id_b = id_s[(i+`SIOEXP_CH_B_LO)*`SIOEXP_ID_W +: `SIOEXP_ID_W];
			end
	end

	// ----------------------------------------
	// Dedicated address decode and bit select
	// ----------------------------------------
	wire page_a = (addr_s & `SIOEXP_SEC_MASK) == `SIOEXP_ADDR_SEC_A;
	wire page_b = (addr_s & `SIOEXP_SEC_MASK) == `SIOEXP_ADDR_SEC_B;
	wire hit_a = sel_s & en_a_s & page_a;
	wire hit_b = sel_s & en_b_s & page_b;
	wire [`SIOEXP_BIT_W-1:0] bit_idx = addr_s[`SIOEXP_BIT_W-1:0];
	// Vector: unit id, chassis number, spare, on-line flags of section
	wire [`SIOEXP_VEC_W-1:0] vec_a = {id_a, num_a, 4'h0, onl_s[`SIOEXP_CH_A_W-1:0]};
	wire [`SIOEXP_VEC_W-1:0] vec_b = {id_b, num_b, 5'h00, onl_s[`SIOEXP_NCH-1:`SIOEXP_CH_B_LO]};
	// Store clock means write; vector bits are read-only, but writing a 1 to either enabled page clears all id enables for one cycle
	wire rd_a = hit_a & ~stclk_s;
	wire rd_b = hit_b & ~stclk_s;
	reg write_seen;
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			write_seen <= 1'b0;
		else
			write_seen <= stclk_rise & (hit_a | hit_b) & wbit_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	reg [`SIOEXP_NCH-1:0] next_id_en;
	always @* begin
		next_id_en = {win_b, win_a};
		if (write_seen)
			next_id_en = {`SIOEXP_NCH{1'b0}};
	end
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_read_bit_o <= 1'b0;
			chassis_id_enable_o <= {`SIOEXP_NCH{1'b0}};
			group_a_irq_o <= 1'b0;
			group_b_irq_o <= 1'b0;
			direct_irq_n_o <= 1'b1;
		end else begin
			chassis_id_enable_o <= next_id_en;
			group_a_irq_o <= |act_a;
			group_b_irq_o <= |act_b;
			direct_irq_n_o <= ~|dreq_s;
			if (rd_a)
				serial_read_bit_o <= vec_a[`SIOEXP_VEC_W-1-bit_idx];
			else if (rd_b)
				serial_read_bit_o <= vec_b[`SIOEXP_VEC_W-1-bit_idx];
			// Dedicated pages never fall through, so a disabled section leaves the line to a second expander
			else if (sel_s & ~stclk_s & ~page_a & ~page_b)
				serial_read_bit_o <= |rbit_s;
			else
				serial_read_bit_o <= 1'b0;
		end
	end
endmodule // sioexp_top

// >>> common/sioexp_defines.vh
// Constants for the serial I/O bus expander
`ifndef SIOEXP_DEFINES_VH
`define SIOEXP_DEFINES_VH
`define SIOEXP_ADDR_W 12
`define SIOEXP_BIT_W 4
`define SIOEXP_VEC_W 16
`define SIOEXP_ID_W 5
`define SIOEXP_NCH 7
`define SIOEXP_ADDR_SEC_A 12'hf80
`define SIOEXP_ADDR_SEC_B 12'hf90
`define SIOEXP_SEC_MASK 12'hff0
`define SIOEXP_CH_A_W 4
`define SIOEXP_CH_B_W 3
`define SIOEXP_CH_B_LO 4
`define SIOEXP_CH_B_NUM0 3'h5
`endif

// >>> rtl/sioexp_sync.v
// Two-flop synchroniser, parameterised width
`timescale 1ns/1ps
module sioexp_sync #(
	parameter W = 1
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta;
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // sioexp_sync

// >>> sim/sioexp_far.sv
// Far-side buffer board model: returns level id of the acknowledged chassis
`timescale 1ns/1ps
module sioexp_far (
	// Clock and id handshake
	input wire core_clk_i,
	input wire [6:0] id_en_i,
	output reg [34:0] id_o
);
	integer k;
	reg [4:0] junk = 5'h0a;
	// Lanes of chassis not enabled wander, so a stale id cannot pass
	always @(posedge core_clk_i) junk <= ~junk;
	always @* begin
		id_o = {7{junk}};
		for (k = 0; k < 7; k++) if (id_en_i[k]) id_o[k * 5 +: 5] = 5'(2 * k + 1);
	end
endmodule // sioexp_far

// >>> sim/sioexp_chk.sv
// Port checker for the serial I/O bus expander
`timescale 1ns/1ps
module sioexp_chk (
	// Watched ports
	input wire core_clk_i,
	input wire arst_n_i,
	// Processor side
	input wire [11:0] serial_addr_i,
	input wire serial_store_clk_i,
	input wire serial_write_bit_i,
	input wire serial_read_bit_o,
	input wire board_select_n_i,
	// Chassis side
	input wire [11:0] chassis_addr_o,
	input wire chassis_store_clk_o,
	input wire chassis_write_bit_o,
	input wire [6:0] chassis_int_present_i,
	input wire [6:0] chassis_id_enable_o,
	input wire [6:0] chassis_direct_req_n_i,
	// Sections and interrupts
	input wire sec_a_enable_i,
	input wire sec_b_enable_i,
	input wire group_a_irq_o,
	input wire group_b_irq_o,
	input wire direct_irq_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Three edges of history before any relation holds
	reg [1:0] age;
	wire ok = age == 2'h3;
	wire [6:0] p = chassis_int_present_i;
	wire ra = sec_a_enable_i & |p[3:0];
	wire rb = sec_b_enable_i & |p[6:4];
	wire idl = &chassis_direct_req_n_i;
	wire [6:0] won = {{3{sec_b_enable_i}} & p[6:4] & (~p[6:4] + 3'h1), {4{sec_a_enable_i}} & p[3:0] & (~p[3:0] + 4'h1)};
	wire [13:0] fan = {serial_addr_i, serial_store_clk_i, serial_write_bit_i};
	wire [13:0] fo = {chassis_addr_o, chassis_store_clk_o, chassis_write_bit_o};
	always @(posedge core_clk_i or negedge arst_n_i)
		if (!arst_n_i) age <= 2'h0;
		else if (!ok) age <= age + 2'h1;
	chk_irq_a: assert property (ok |-> group_a_irq_o == $past(ra, 3)) else $error("irq a");
	chk_irq_b: assert property (ok |-> group_b_irq_o == $past(rb, 3)) else $error("irq b");
	chk_direct_merge: assert property (ok |-> direct_irq_n_o == $past(idl, 3)) else $error("irq c");
	chk_id_winner: assert property (ok |-> chassis_id_enable_o == $past(won, 3)) else $error("id en");
	chk_id_single: assert property ($onehot0(chassis_id_enable_o[3:0])) else $error("id a");
	chk_fan_out: assert property (ok |-> fo == $past(fan, 3)) else $error("fan");
	chk_desel_quiet: assert property (ok && $rose(board_select_n_i) |-> ##3 !serial_read_bit_o) else $error("sel");
	chk_store_quiet: assert property (ok && $past(serial_store_clk_i, 3) |-> !serial_read_bit_o) else $error("st");
	cover property (group_a_irq_o && group_b_irq_o);
	cover property (!direct_irq_n_o);
	cover property ($rose(chassis_store_clk_o));
endmodule // sioexp_chk
bind sioexp_top sioexp_chk i_sioexp_chk (
	.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i),
	.serial_addr_i(serial_addr_i),
	.serial_store_clk_i(serial_store_clk_i),
	.serial_write_bit_i(serial_write_bit_i),
	.serial_read_bit_o(serial_read_bit_o),
	.board_select_n_i(board_select_n_i),
	.chassis_addr_o(chassis_addr_o),
	.chassis_store_clk_o(chassis_store_clk_o),
	.chassis_write_bit_o(chassis_write_bit_o),
	.chassis_int_present_i(chassis_int_present_i),
	.chassis_id_enable_o(chassis_id_enable_o),
	.chassis_direct_req_n_i(chassis_direct_req_n_i),
	.sec_a_enable_i(sec_a_enable_i),
	.sec_b_enable_i(sec_b_enable_i),
	.group_a_irq_o(group_a_irq_o),
	.group_b_irq_o(group_b_irq_o),
	.direct_irq_n_o(direct_irq_n_o)
);

// >>> sim/testbench.sv
// Self-checking bench for the serial I/O bus expander
`timescale 1ns/1ps
module testbench;
	reg core_clk_i = 0, arst_n_i = 0, serial_store_clk_i = 0, serial_write_bit_i = 0;
	reg board_select_n_i = 1, sec_a_enable_i = 1, sec_b_enable_i = 1;
	reg [11:0] serial_addr_i = 0;
	reg [6:0] chassis_read_bit_i = 0, chassis_int_present_i = 0, chassis_online_i = 0, chassis_direct_req_n_i = 7'h7f;
	wire serial_read_bit_o, chassis_store_clk_o, chassis_write_bit_o, group_a_irq_o, group_b_irq_o, direct_irq_n_o;
	wire [11:0] chassis_addr_o;
	wire [6:0] chassis_id_enable_o;
	wire [34:0] chassis_id_i;
	integer err_total = 0, total_checks = 0, seed = 32'h7cb8, i, k, b;
	reg [15:0] v;
	always #12.5 core_clk_i = ~core_clk_i;
	sioexp_top i_sioexp_top (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.serial_addr_i(serial_addr_i),
		.serial_store_clk_i(serial_store_clk_i),
		.serial_write_bit_i(serial_write_bit_i),
		.serial_read_bit_o(serial_read_bit_o),
		.board_select_n_i(board_select_n_i),
		.chassis_addr_o(chassis_addr_o),
		.chassis_store_clk_o(chassis_store_clk_o),
		.chassis_write_bit_o(chassis_write_bit_o),
		.chassis_read_bit_i(chassis_read_bit_i),
		.chassis_int_present_i(chassis_int_present_i),
		.chassis_online_i(chassis_online_i),
		.chassis_id_i(chassis_id_i),
		.chassis_id_enable_o(chassis_id_enable_o),
		.chassis_direct_req_n_i(chassis_direct_req_n_i),
		.sec_a_enable_i(sec_a_enable_i),
		.sec_b_enable_i(sec_b_enable_i),
		.group_a_irq_o(group_a_irq_o),
		.group_b_irq_o(group_b_irq_o),
		.direct_irq_n_o(direct_irq_n_o)
	);
	sioexp_far i_sioexp_far (.core_clk_i(core_clk_i), .id_en_i(chassis_id_enable_o), .id_o(chassis_id_i));
	task cmp(input [15:0] g, input [15:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task hold;
		repeat (4) @(negedge core_clk_i);
	endtask
	// Lowest chassis number of the section wins
	function [15:0] vexp(input integer b);
		integer c, j;
		c = 0;
		for (j = 6; j >= 0; j--) if (chassis_int_present_i[j] && (j > 3) == b) c = j + 1;
		vexp = {5'(2 * c - 1), 3'(c), b ? {5'h00, chassis_online_i[6:4]} : {4'h0, chassis_online_i[3:0]}};
	endfunction
	initial begin
		hold;
		hold;
		cmp(direct_irq_n_o, 1);
		cmp(chassis_id_enable_o, 0);
		arst_n_i = 1;
		for (i = 0; i < 40; i++) begin
			chassis_int_present_i = i < 2 ? 7'h7f >> i * 3 : $random(seed);
			chassis_online_i = $random(seed);
			chassis_direct_req_n_i = i == 0 ? 7'h7f : $random(seed);
			chassis_read_bit_i = $random(seed);
			{sec_a_enable_i, sec_b_enable_i} = i < 4 ? 2'h3 : $random(seed);
			board_select_n_i = 0;
			hold;
			cmp(group_a_irq_o, sec_a_enable_i & |chassis_int_present_i[3:0]);
			cmp(group_b_irq_o, sec_b_enable_i & |chassis_int_present_i[6:4]);
			cmp(direct_irq_n_o, &chassis_direct_req_n_i);
			b = i & 1;
			v = vexp(b);
			for (k = 0; k < 16; k++) begin
				serial_addr_i = (b ? 12'hf90 : 12'hf80) | k;
				hold;
				// Id lines float when nothing is pending
				if (v[10:8] || k > 4) cmp(serial_read_bit_o, (b ? sec_b_enable_i : sec_a_enable_i) & v[15 - k]);
			end
			serial_addr_i = $random(seed) & 12'h7ff;
			hold;
			cmp(serial_read_bit_o, |chassis_read_bit_i);
			serial_write_bit_i = $random(seed);
			serial_store_clk_i = 1;
			hold;
			cmp(chassis_write_bit_o, serial_write_bit_i);
			cmp(serial_read_bit_o, 0);
			serial_store_clk_i = 0;
			board_select_n_i = 1;
			chassis_int_present_i = 0;
			hold;
			cmp(serial_read_bit_o, 0);
			$display("test %0d done", i);
		end
		stop_test;
	end
	initial begin
		#200000;
		err_total++;
		stop_test;
	end
endmodule // testbench
